// *** inc/param_cmd_map.vh ***
`ifndef PARAM_CMD_MAP_VH
`define PARAM_CMD_MAP_VH

// Frame layout
`define FRAME_LEN 4'h9
`define FRAME_LAST 4'h8

// Instruction codes
`define INSTR_AXIS_READ 8'h06
`define INSTR_AXIS_STORE 8'h07
`define INSTR_AXIS_RESTORE 8'h08
`define INSTR_GLOBAL_WRITE 8'h09
`define INSTR_GLOBAL_READ 8'h0A

// Bank numbers
`define BANK_MODULE 8'h00
`define BANK_USER 8'h02
`define BANK_IRQ 8'h03
`define AXIS_BANK 8'h00

// Reply status codes
`define STATUS_OK 8'd100
`define STATUS_BAD_SUM 8'd1
`define STATUS_BAD_CMD 8'd2
`define STATUS_BAD_TYPE 8'd3
`define STATUS_BAD_VALUE 8'd4

// Parameter table geometry
`define PARAM_IDX_W 4
`define PARAM_DEPTH 16
`define PARAM_LAST 4'hF

// Address of the reply frame, arbitrary host address
`define REPLY_ADDR 8'h02

// Reset values
`define RST_WORD 32'h0000_0000
`define RST_BYTE 8'h00
`define RST_IDX 4'h0

`endif

// *** src/axis_global_param_commands.v ***
// Operation
// [RL1] Axis read (6) fetches parameter selected by type into accumulator.
// [RL2] Direct mode: axis read replies status 100 with parameter value.
// [RL3] Direct mode leaves accumulator alone; standalone mode loads it.
// [RL4] Axis store (7) copies current parameter into EEPROM; value ignored.
// [RL5] Store and restore select parameter by type, axis by bank field, 0.
// [RL6] Axis restore (8) reloads selected parameter from EEPROM.
// [RL7] After power up all axis parameters restore from EEPROM automatically.
// [RL8] Global write (9) copies 32-bit value into type/bank 0, 2 or 3.
// [RL9] Bank 0 module settings, bank 2 user variables, bank 3 interrupt setup.
// [RL10] Bank 0 writes also save the setting into EEPROM automatically.
// [RL11] Global read (10) copies selected global into accumulator; value ignored.
// [RL12] Every global in every defined bank can be read back.
// [RL13] Frame: address, instruction, type, bank, value MSB first, checksum.
// [RL14] Checksum is modulo-256 sum of eight preceding bytes, checked here.
`timescale 1ns/1ns
`default_nettype none
`include "param_cmd_map.vh"

module axis_global_param_commands (
  input wire mclk,
  input wire rst_n,
  input wire rx_valid,
  input wire [7:0] rx_byte,
  input wire [7:0] module_addr,
  input wire standalone,
  input wire axis_wr_en,
  input wire [3:0] axis_wr_idx,
  input wire [31:0] axis_wr_data,
  output reg tx_valid_q,
  output reg [7:0] tx_addr_q,
  output reg [7:0] tx_status_q,
  output reg [7:0] tx_instr_q,
  output reg [31:0] tx_value_q,
  output reg [31:0] accu_q,
  output reg busy_q
);

  localparam ST_RESTORE = 2'b01;
  localparam ST_IDLE = 2'b10;

  wire fr_valid;
  wire fr_sum_ok;
  wire [7:0] fr_addr;
  wire [7:0] fr_instr;
  wire [7:0] fr_type;
  wire [7:0] fr_bank;
  wire [31:0] fr_value;

  reg [1:0] state_q;
  reg [3:0] rst_idx_q;

  // Working copies; only the axis and module tables have nonvolatile images
  reg [31:0] axis_ram [0:`PARAM_DEPTH-1];
  reg [31:0] axis_ee [0:`PARAM_DEPTH-1];
  reg [31:0] glob_mod [0:`PARAM_DEPTH-1];
  reg [31:0] glob_mod_ee [0:`PARAM_DEPTH-1];
  reg [31:0] glob_user [0:`PARAM_DEPTH-1];
  reg [31:0] glob_irq [0:`PARAM_DEPTH-1];

  reg [7:0] rep_status;
  reg [31:0] rep_value;
  reg acc_load;
  reg ax_store;
  reg ax_restore;
  reg gp_write;

  wire [3:0] idx;
  wire type_ok;
  wire fr_hit;

  frame_rx u_frame (
    .mclk(mclk),
    .rst_n(rst_n),
    .rx_valid(rx_valid),
    .rx_byte(rx_byte),
    .frame_valid_q(fr_valid),
    .sum_ok_q(fr_sum_ok),
    .addr_q(fr_addr),
    .instr_q(fr_instr),
    .type_q(fr_type),
    .bank_q(fr_bank),
    .value_q(fr_value)
  );

  // Table is 16 deep, so only low type bits index it
  assign idx = fr_type[3:0];
  assign type_ok = (fr_type[7:4] == 4'h0);
  // Frames are dropped during restore; no buffer for them
  assign fr_hit = fr_valid && (fr_addr == module_addr) && (state_q == ST_IDLE);

  // Command decode, one frame per cycle
  always @* begin
    rep_status = `STATUS_OK;
    rep_value = `RST_WORD;
    acc_load = 1'b0;
    ax_store = 1'b0;
    ax_restore = 1'b0;
    gp_write = 1'b0;
    if (!fr_sum_ok) begin
      rep_status = `STATUS_BAD_SUM; // [RL14]
    end else begin
      case (fr_instr)
        `INSTR_AXIS_READ: begin
          if (!type_ok) begin
            rep_status = `STATUS_BAD_TYPE;
          end else if (fr_bank != `AXIS_BANK) begin
            rep_status = `STATUS_BAD_VALUE;
          end else begin
            rep_value = axis_ram[idx]; // [RL1] [RL2]
            acc_load = standalone; // [RL3]
          end
        end
        `INSTR_AXIS_STORE, `INSTR_AXIS_RESTORE: begin
          if (!type_ok) begin
            rep_status = `STATUS_BAD_TYPE; // [RL5]
          end else if (fr_bank != `AXIS_BANK) begin
            rep_status = `STATUS_BAD_VALUE; // [RL5]
          end else begin
            ax_store = (fr_instr == `INSTR_AXIS_STORE); // [RL4]
            ax_restore = (fr_instr == `INSTR_AXIS_RESTORE); // [RL6]
          end
        end
        `INSTR_GLOBAL_WRITE, `INSTR_GLOBAL_READ: begin
          if (!type_ok) begin
            rep_status = `STATUS_BAD_TYPE;
          end else begin
            case (fr_bank)
              `BANK_MODULE: rep_value = glob_mod[idx]; // [RL9] [RL12]
              `BANK_USER: rep_value = glob_user[idx]; // [RL9] [RL12]
              `BANK_IRQ: rep_value = glob_irq[idx]; // [RL9] [RL12]
              default: rep_status = `STATUS_BAD_VALUE;
            endcase
            if (rep_status == `STATUS_OK) begin
              gp_write = (fr_instr == `INSTR_GLOBAL_WRITE); // [RL8]
              acc_load = (fr_instr == `INSTR_GLOBAL_READ); // [RL11]
            end
            if (fr_instr == `INSTR_GLOBAL_WRITE) begin
              rep_value = `RST_WORD;
            end
          end
        end
        default: rep_status = `STATUS_BAD_CMD;
      endcase
    end
  end

  // Sequencer: power-up restore sweep, then command service
  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= ST_RESTORE;
      rst_idx_q <= `RST_IDX;
      busy_q <= 1'b1;
    end else begin
      case (state_q)
        ST_RESTORE: begin
          rst_idx_q <= rst_idx_q + 4'h1; // [RL7]
          if (rst_idx_q == `PARAM_LAST) begin
            state_q <= ST_IDLE;
            busy_q <= 1'b0;
          end
        end
        ST_IDLE: begin
          state_q <= ST_IDLE;
        end
        default: begin
          state_q <= ST_RESTORE;
          rst_idx_q <= `RST_IDX;
          busy_q <= 1'b1;
        end
      endcase
    end
  end

  // Tables carry no reset; the nonvolatile images must survive rst_n
  always @(posedge mclk) begin
    if (state_q == ST_RESTORE) begin
      axis_ram[rst_idx_q] <= axis_ee[rst_idx_q]; // [RL7]
      glob_mod[rst_idx_q] <= glob_mod_ee[rst_idx_q];
      glob_user[rst_idx_q] <= `RST_WORD;
      glob_irq[rst_idx_q] <= `RST_WORD;
    end else begin
      // Motion core writes lose to a restore frame of any entry
      if (fr_hit && ax_restore) begin
        axis_ram[idx] <= axis_ee[idx]; // [RL6]
      end else if (axis_wr_en) begin
        axis_ram[axis_wr_idx] <= axis_wr_data;
      end
      if (fr_hit && ax_store) begin
        axis_ee[idx] <= axis_ram[idx]; // [RL4]
      end
      if (fr_hit && gp_write) begin
        case (fr_bank)
          `BANK_MODULE: begin
            glob_mod[idx] <= fr_value; // [RL8]
            glob_mod_ee[idx] <= fr_value; // [RL10]
          end
          `BANK_USER: glob_user[idx] <= fr_value; // [RL8]
          `BANK_IRQ: glob_irq[idx] <= fr_value; // [RL8]
          default: begin
          end
        endcase
      end
    end
  end

  // Reply and accumulator; standalone programs get no reply frame
  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      tx_valid_q <= 1'b0;
      tx_addr_q <= `RST_BYTE;
      tx_status_q <= `RST_BYTE;
      tx_instr_q <= `RST_BYTE;
      tx_value_q <= `RST_WORD;
      accu_q <= `RST_WORD;
    end else begin
      tx_valid_q <= fr_hit && !standalone; // [RL2]
      if (fr_hit && !standalone) begin
        tx_addr_q <= `REPLY_ADDR;
        tx_status_q <= rep_status; // [RL2]
        tx_instr_q <= fr_instr;
        tx_value_q <= rep_value; // [RL2]
      end
      if (fr_hit && acc_load) begin
        accu_q <= rep_value; // [RL1] [RL11]
      end
    end
  end

endmodule // axis_global_param_commands
`default_nettype wire

// *** src/frame_rx.v ***
`timescale 1ns/1ns
`default_nettype none
`include "param_cmd_map.vh"

module frame_rx (
  input wire mclk,
  input wire rst_n,
  input wire rx_valid,
  input wire [7:0] rx_byte,
  output reg frame_valid_q,
  output reg sum_ok_q,
  output reg [7:0] addr_q,
  output reg [7:0] instr_q,
  output reg [7:0] type_q,
  output reg [7:0] bank_q,
  output reg [31:0] value_q
);

  reg [3:0] cnt_q;
  reg [7:0] sum_q;

  // Byte collector; fields in fixed order, value MSB first
  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q <= `RST_IDX;
      sum_q <= `RST_BYTE;
      frame_valid_q <= 1'b0;
      sum_ok_q <= 1'b0;
      addr_q <= `RST_BYTE;
      instr_q <= `RST_BYTE;
      type_q <= `RST_BYTE;
      bank_q <= `RST_BYTE;
      value_q <= `RST_WORD;
    end else begin
      frame_valid_q <= 1'b0;
      if (rx_valid) begin
        case (cnt_q)
          4'h0: addr_q <= rx_byte; // [RL13]
          4'h1: instr_q <= rx_byte;
          4'h2: type_q <= rx_byte;
          4'h3: bank_q <= rx_byte;
          4'h4, 4'h5, 4'h6, 4'h7: value_q <= {value_q[23:0], rx_byte}; // [RL13]
          default: begin
          end
        endcase
        if (cnt_q == `FRAME_LAST) begin
          // Modulo-256 sum of the eight bytes before it
          sum_ok_q <= (sum_q == rx_byte); // [RL14]
          frame_valid_q <= 1'b1;
          cnt_q <= `RST_IDX;
          sum_q <= `RST_BYTE;
        end else begin
          sum_q <= sum_q + rx_byte; // [RL14]
          cnt_q <= cnt_q + 4'h1;
        end
      end
    end
  end

endmodule // frame_rx
`default_nettype wire

// *** tb/axis_global_param_commands_test.sv ***
`timescale 1ns/1ns
`default_nettype none
`include "param_cmd_map.vh"
module axis_global_param_commands_test;
  logic mclk, rst_n, standalone, axis_wr_en, rx_valid, tx_valid_q, busy_q;
  logic [3:0] axis_wr_idx;
  logic [7:0] rx_byte, tx_addr_q, tx_status_q, tx_instr_q;
  logic [31:0] axis_wr_data, tx_value_q, accu_q;
  int n_mismatch, comparisons;
  host_model i_host_model (.mclk, .rx_valid, .rx_byte);
  axis_global_param_commands i_axis_global_param_commands (.mclk, .rst_n, .rx_valid,
    .rx_byte, .module_addr(8'h01), .standalone, .axis_wr_en, .axis_wr_idx, .axis_wr_data,
    .tx_valid_q, .tx_addr_q, .tx_status_q, .tx_instr_q, .tx_value_q, .accu_q, .busy_q);
  // Free-running 4 ns clock
  initial begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end
  task chk(input string n, input logic [31:0] e, input logic [31:0] v);
    comparisons++;
    if (v !== e) begin
      n_mismatch++;
      $display("unexpected %s: expected %h, seen %h", n, e, v);
    end
  endtask
  // Status 0 means the frame must be dropped silently
  task cmd(input logic [7:0] ins, typ, bank, input logic [31:0] val, input logic [7:0] bad,
    st, input logic [31:0] rv, input logic [7:0] a = 8'h01);
    logic seen;
    seen = 1'b0;
    i_host_model.send({a, ins, typ, bank, val}, bad);
    repeat (6) begin
      @(posedge mclk) #1;
      if (tx_valid_q === 1'b1 && !seen) begin
        seen = 1'b1;
        chk("status", {24'h0, st}, {24'h0, tx_status_q});
        chk("value", rv, tx_value_q);
        chk("instr", {24'h0, ins}, {24'h0, tx_instr_q});
        chk("addr", {24'h0, `REPLY_ADDR}, {24'h0, tx_addr_q});
      end
    end
    chk("reply", {31'h0, st != 8'h00}, {31'h0, seen});
  endtask
  task axis_set(input logic [3:0] i, input logic [31:0] d);
    @(posedge mclk) #1;
    axis_wr_en = 1'b1;
    axis_wr_idx = i;
    axis_wr_data = d;
    @(posedge mclk) #1;
    axis_wr_en = 1'b0;
  endtask
  task do_reset;
    rst_n = 1'b0;
    repeat (8) @(posedge mclk);
    #1 rst_n = 1'b1;
    // Sweep holds busy for exactly sixteen edges after release
    repeat (15) @(posedge mclk);
    #1 chk("busy", 1, {31'h0, busy_q});
    @(posedge mclk) #1;
    chk("busy", 0, {31'h0, busy_q});
  endtask
  task t_axis;
    axis_set(4'h3, 32'h1234_5678);
    cmd(`INSTR_AXIS_READ, 8'h03, 8'h00, 32'hFFFF_FFFF, 0, 100, 32'h1234_5678);
    chk("accu", 0, accu_q);
    cmd(`INSTR_AXIS_STORE, 8'h03, 8'h00, 32'hDEAD_BEEF, 0, 100, 0);
    axis_set(4'h3, 32'h0BAD_F00D);
    // Refused store must not overwrite the image with the new working value
    cmd(`INSTR_AXIS_STORE, 8'h03, 8'h01, 0, 0, 4, 0);
    cmd(`INSTR_AXIS_RESTORE, 8'h03, 8'h00, 0, 0, 100, 0);
    cmd(`INSTR_AXIS_READ, 8'h03, 8'h00, 0, 0, 100, 32'h1234_5678);
    cmd(`INSTR_AXIS_READ, 8'h03, 8'h01, 0, 0, 4, 0);
  endtask
  task t_global;
    for (int k = 0; k < 3; k++) begin
      cmd(`INSTR_GLOBAL_WRITE, 8'h05, 8'(k + (k > 0)), 32'hA5A5_0000 + k, 0, 100, 0);
      cmd(`INSTR_GLOBAL_READ, 8'h05, 8'(k + (k > 0)), 0, 0, 100, 32'hA5A5_0000 + k);
      chk("accu", 32'hA5A5_0000 + k, accu_q);
    end
    cmd(`INSTR_GLOBAL_WRITE, 8'h05, 8'h01, 0, 0, 4, 0);
  endtask
  task t_refuse;
    cmd(`INSTR_GLOBAL_READ, 8'h05, 8'h02, 0, 8'h01, 1, 0);
    cmd(`INSTR_GLOBAL_READ, 8'h05, 8'h02, 0, 0, 0, 0, 8'h07);
    // Instruction outside this block and an oversized type index
    cmd(8'h05, 8'h03, 8'h00, 32'h0000_0001, 0, 2, 0);
    cmd(`INSTR_GLOBAL_READ, 8'h42, 8'h00, 0, 0, 3, 0);
    chk("accu", 32'hA5A5_0002, accu_q);
  endtask
  task t_persist;
    cmd(`INSTR_GLOBAL_WRITE, 8'h09, 8'h00, 32'h0000_0042, 0, 100, 0);
    cmd(`INSTR_GLOBAL_WRITE, 8'h09, 8'h02, 32'h0000_0077, 0, 100, 0);
    do_reset;
    cmd(`INSTR_GLOBAL_READ, 8'h09, 8'h00, 0, 0, 100, 32'h0000_0042);
    cmd(`INSTR_GLOBAL_READ, 8'h09, 8'h02, 0, 0, 100, 0);
    cmd(`INSTR_AXIS_READ, 8'h03, 8'h00, 0, 0, 100, 32'h1234_5678);
  endtask
  task t_standalone;
    standalone = 1'b1;
    cmd(`INSTR_AXIS_READ, 8'h03, 8'h00, 0, 0, 0, 0);
    chk("accu", 32'h1234_5678, accu_q);
    standalone = 1'b0;
  endtask
  task end_of_test;
    $display("mismatches %0d, comparisons %0d", n_mismatch, comparisons);
    if (n_mismatch == 0 && comparisons > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  // Main sequence
  initial begin
    rst_n = 1'b0;
    standalone = 1'b0;
    axis_wr_en = 1'b0;
    axis_wr_idx = 4'h0;
    axis_wr_data = 32'h0000_0000;
    do_reset;
    t_axis;
    t_global;
    t_refuse;
    t_persist;
    t_standalone;
    end_of_test;
  end
  // Watchdog well beyond the few hundred cycles needed
  initial begin
    repeat (5000) @(posedge mclk);
    n_mismatch++;
    end_of_test;
  end
endmodule // axis_global_param_commands_test
`default_nettype wire

// *** tb/host_model.sv ***
`timescale 1ns/1ns
`default_nettype none
module host_model (
  input wire logic mclk,
  output logic rx_valid,
  output logic [7:0] rx_byte
);
  // Idle line before first frame
  initial begin
    rx_valid = 1'b0;
    rx_byte = 8'h00;
  end
  // Eight bytes MSB first, then the sum; bad offsets the sum
  task send(input logic [63:0] f, input logic [7:0] bad);
    logic [7:0] s;
    s = bad;
    for (int i = 7; i >= 0; i--) begin
      @(posedge mclk) #1;
      rx_valid = 1'b1;
      rx_byte = f[i*8 +: 8];
      s = s + rx_byte;
    end
    @(posedge mclk) #1;
    rx_byte = s;
    @(posedge mclk) #1;
    rx_valid = 1'b0;
    rx_byte = ~s; // Released line must not look valid
  endtask
endmodule // host_model
`default_nettype wire

// *** tb/param_cmd_props.sv ***
`timescale 1ns/1ns
`default_nettype none
`include "param_cmd_map.vh"
module param_cmd_props (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic standalone,
  input wire logic tx_valid_q,
  input wire logic [7:0] tx_addr_q,
  input wire logic [7:0] tx_status_q,
  input wire logic [7:0] tx_instr_q,
  input wire logic [31:0] tx_value_q,
  input wire logic [31:0] accu_q,
  input wire logic busy_q
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);
  // Reply strobe rises and falls again
  sequence pulse_s;
    tx_valid_q ##1 !tx_valid_q;
  endsequence
  reply_pulse_a: assert property (tx_valid_q |-> pulse_s)
    else $error("reply strobe longer than a cycle");
  reply_addr_a: assert property (tx_valid_q |-> tx_addr_q == `REPLY_ADDR)
    else $error("reply address wrong");
  busy_drop_a: assert property (busy_q |-> !tx_valid_q)
    else $error("reply during restore sweep");
  // Sixteen entries swept one per cycle, so busy stood for all of them
  sweep_len_a: assert property ($fell(busy_q) |-> $past(busy_q, 16))
    else $error("restore sweep too short");
  direct_accu_a: assert property (tx_valid_q && tx_instr_q == `INSTR_AXIS_READ
    |-> $stable(accu_q))
    else $error("direct axis read touched accumulator");
  stand_quiet_a: assert property (standalone && $past(standalone, 2) |-> !tx_valid_q)
    else $error("reply in standalone mode");
  global_accu_a: assert property (tx_valid_q && tx_instr_q == `INSTR_GLOBAL_READ
    && tx_status_q == `STATUS_OK |-> accu_q == tx_value_q)
    else $error("global read accumulator differs");
  error_keep_a: assert property (tx_valid_q && tx_status_q != `STATUS_OK
    |-> $stable(accu_q) && tx_value_q == 0)
    else $error("refused frame changed state");
  write_zero_a: assert property (tx_valid_q && tx_instr_q inside {8'h07, 8'h08, 8'h09}
    |-> tx_value_q == 0)
    else $error("store or write reply carries value");
endmodule // param_cmd_props
bind axis_global_param_commands param_cmd_props i_param_cmd_props (.mclk, .rst_n, .standalone,
  .tx_valid_q, .tx_addr_q, .tx_status_q, .tx_instr_q, .tx_value_q, .accu_q, .busy_q);
`default_nettype wire
